// file: rtl/splpp_pkg.sv
// constants shared by the strap latch and port power pin logic
package splpp_pkg;
  localparam int unsigned SPLPP_PORTS = 2;
  localparam int unsigned SPLPP_SYNC_STAGES = 3;
  // time the power switch is allowed to settle before overcurrent is believed
  localparam int unsigned SPLPP_OC_BLANK_NS = 100;
  localparam int unsigned SPLPP_CLK_NS = 10;
  localparam int unsigned SPLPP_OC_BLANK_CYC =
    (SPLPP_OC_BLANK_NS + SPLPP_CLK_NS - 1) / SPLPP_CLK_NS;
  // strap layout inside the captured word
  localparam int unsigned SPLPP_STRAP_W = 4;
  localparam int unsigned SPLPP_ST_FIXED_LSB = 0;
  localparam int unsigned SPLPP_ST_FIXED_W = 2;
  localparam int unsigned SPLPP_ST_CHARGE = 2;
  localparam int unsigned SPLPP_ST_MGMT = 3;
  localparam logic [3:0] SPLPP_STRAP_RST = 4'h0;
  // interrupt status / mask bit positions
  localparam int unsigned SPLPP_EV_OC1 = 0;
  localparam int unsigned SPLPP_EV_OC2 = 1;
  localparam int unsigned SPLPP_EV_VBUS = 2;
  localparam int unsigned SPLPP_EV_W = 3;
  // register offsets
  localparam logic [3:0] SPLPP_REG_CTRL = 4'h0;
  localparam logic [3:0] SPLPP_REG_STAT = 4'h1;
  localparam logic [3:0] SPLPP_REG_IRQ = 4'h2;
  localparam logic [3:0] SPLPP_REG_MASK = 4'h3;
  localparam logic [3:0] SPLPP_REG_STRAP = 4'h4;
  localparam logic [3:0] SPLPP_REG_ROM = 4'h5;
  localparam logic [7:0] SPLPP_CTRL_RST = 8'h00;
  localparam logic [2:0] SPLPP_MASK_RST = 3'h0;
  typedef enum logic [1:0] {SPLPP_LINK_IDLE, SPLPP_LINK_DROP, SPLPP_LINK_UP} splpp_link_t;
endpackage

// file: rtl/splpp_sync.sv
// three stage synchroniser for one pin level
`timescale 1ns/1ns
module splpp_sync
  import splpp_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk_in, // system clock
  input wire logic reset_in, // synchronous reset
  input wire logic pin_in, // raw pin level
  output logic level_out // filtered level
);
  logic [2:0] sync_q;

  // shift the pin through three flops
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sync_q <= {3{RESET_VAL}};
    end else begin
      sync_q <= {sync_q[1:0], pin_in};
    end
  end

  // change only once stages two and three agree; stage one is never looked at
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      level_out <= RESET_VAL;
    end else if (sync_q[1] == sync_q[2]) begin
      level_out <= sync_q[2];
    end
  end
endmodule // splpp_sync

// file: rtl/splpp_top.sv
// strap latch, port power pins, upstream sense and shared serial pin mux
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module splpp_top
  import splpp_pkg::*;
(
  input wire logic clk_in, // 100 MHz reference clock
  input wire logic reset_in, // power-on reset, active high
  input wire logic ext_reset_n_in, // external chip reset pin, low active
  input wire logic [1:0] fixed_port_count_strap_in, // fixed port strap pins
  input wire logic charge_enable_strap_in, // charge strap pin
  input wire logic mgmt_mode_strap_in, // shared pins: 1 management slave, 0 rom
  input wire logic upstream_power_sense_in, // upstream bus power pin
  input wire logic port_one_power_ctl_in, // port 1 pin level
  output logic port_one_power_ctl_out, // port 1 pin drive value
  output logic port_one_power_ctl_oe_n_out, // port 1 drive enable, low drives
  input wire logic port_two_power_ctl_in, // port 2 pin level
  output logic port_two_power_ctl_out, // port 2 pin drive value
  output logic port_two_power_ctl_oe_n_out, // port 2 drive enable, low drives
  output logic rom_select_n_out, // rom chip select, low active
  input wire logic mgmt_bus_clock_in, // shared clock pin level
  output logic mgmt_bus_clock_out, // shared clock pin value
  output logic mgmt_bus_clock_oe_n_out, // shared clock enable, low drives
  input wire logic mgmt_bus_data_in, // shared data pin level
  output logic mgmt_bus_data_out, // shared data pin value
  output logic mgmt_bus_data_oe_n_out, // shared data enable, low drives
  input wire logic rom_serial_in, // rom data in pin
  input wire logic [3:0] addr_in, // register address
  input wire logic [7:0] wdata_in, // register write data
  input wire logic wr_in, // write strobe
  input wire logic rd_in, // read strobe
  output logic [7:0] rdata_out, // read data, cycle after rd_in
  output logic [1:0] fixed_port_count_out, // ports reported non-removable
  output logic charge_enable_out, // battery charging enabled
  output logic mgmt_mode_out, // shared pins in management mode
  output logic upstream_power_out, // upstream bus power present
  output logic link_attach_out, // upstream link may connect
  output logic [1:0] overcurrent_out, // live overcurrent per port
  output logic mgmt_scl_out, // sampled management clock
  output logic mgmt_sda_out, // sampled management data
  output logic rom_miso_out, // sampled rom data
  output logic irq_out // level interrupt
);
  logic ext_rst_n_s, vbus_s, p1_s, p2_s, scl_s, sda_s, miso_s;
  logic ext_rst_n_q, por_cap_q;
  logic [3:0] strap_q;
  logic [7:0] ctrl_q;
  logic [2:0] irq_q, mask_q;
  logic [2:0] rom_q;
  logic [7:0] rdata_q;
  logic vbus_q;
  logic [1:0] oc_q, oc_prev_q;
  logic [7:0] blank1_q, blank2_q;
  logic [2:0] ev;
  logic capture;
  splpp_link_t link_q;

  // ***************************************
  // pin synchronisers
  // ***************************************
  splpp_sync #(.RESET_VAL(1'b1)) u_rst (.clk_in(clk_in), .reset_in(reset_in),
    .pin_in(ext_reset_n_in), .level_out(ext_rst_n_s));
  splpp_sync #(.RESET_VAL(1'b0)) u_vbus (.clk_in(clk_in), .reset_in(reset_in),
    .pin_in(upstream_power_sense_in), .level_out(vbus_s));
  splpp_sync #(.RESET_VAL(1'b0)) u_p1 (.clk_in(clk_in), .reset_in(reset_in),
    .pin_in(port_one_power_ctl_in), .level_out(p1_s));
  splpp_sync #(.RESET_VAL(1'b0)) u_p2 (.clk_in(clk_in), .reset_in(reset_in),
    .pin_in(port_two_power_ctl_in), .level_out(p2_s));
  splpp_sync #(.RESET_VAL(1'b1)) u_scl (.clk_in(clk_in), .reset_in(reset_in),
    .pin_in(mgmt_bus_clock_in), .level_out(scl_s));
  splpp_sync #(.RESET_VAL(1'b1)) u_sda (.clk_in(clk_in), .reset_in(reset_in),
    .pin_in(mgmt_bus_data_in), .level_out(sda_s));
  splpp_sync #(.RESET_VAL(1'b0)) u_miso (.clk_in(clk_in), .reset_in(reset_in),
    .pin_in(rom_serial_in), .level_out(miso_s));

  // ***************************************
  // strap capture
  // ***************************************
  // power-on capture is taken the first cycle after reset releases, since a
  // synchronous reset may not load a pin level
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ext_rst_n_q <= 1'b1;
      por_cap_q <= 1'b1;
    end else begin
      ext_rst_n_q <= ext_rst_n_s;
      por_cap_q <= 1'b0;
    end
  end

  // the reset pin is low active, so its release is the rising edge
  assign capture = por_cap_q || (ext_rst_n_s && !ext_rst_n_q);

  // straps only move on a capture event, never from later pin activity
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      strap_q <= SPLPP_STRAP_RST;
    end else if (capture) begin
      strap_q <= {mgmt_mode_strap_in, charge_enable_strap_in, fixed_port_count_strap_in};
    end
  end

  assign fixed_port_count_out = strap_q[SPLPP_ST_FIXED_LSB +: SPLPP_ST_FIXED_W];
  assign charge_enable_out = strap_q[SPLPP_ST_CHARGE];
  assign mgmt_mode_out = strap_q[SPLPP_ST_MGMT];

  // ***************************************
  // register port
  // ***************************************
  // ctrl: bit0/1 port power request, bit2 soft detach
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_q <= SPLPP_CTRL_RST;
      mask_q <= SPLPP_MASK_RST;
      rom_q <= 3'h0;
    end else if (wr_in) begin
      case (addr_in)
        SPLPP_REG_CTRL: ctrl_q <= wdata_in;
        SPLPP_REG_MASK: mask_q <= wdata_in[2:0];
        SPLPP_REG_ROM: rom_q <= wdata_in[2:0];
        default: ;
      endcase
    end
  end

  // read data stands one cycle only
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_q <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        SPLPP_REG_CTRL: rdata_q <= ctrl_q;
        SPLPP_REG_STAT: rdata_q <= {3'h0, link_q == SPLPP_LINK_UP, vbus_q, miso_s, oc_q};
        SPLPP_REG_IRQ: rdata_q <= {5'h00, irq_q};
        SPLPP_REG_MASK: rdata_q <= {5'h00, mask_q};
        SPLPP_REG_STRAP: rdata_q <= {4'h0, strap_q};
        SPLPP_REG_ROM: rdata_q <= {5'h00, rom_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign rdata_out = rdata_q;

  // ***************************************
  // port power and overcurrent
  // ***************************************
  // pin drives only while powered; released it reads the monitor's flag
  assign port_one_power_ctl_out = 1'b1;
  assign port_two_power_ctl_out = 1'b1;
  assign port_one_power_ctl_oe_n_out = !ctrl_q[0];
  assign port_two_power_ctl_oe_n_out = !ctrl_q[1];

  // blanking hides our own drive and the switch settling from the sense
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      blank1_q <= 8'h00;
      blank2_q <= 8'h00;
    end else begin
      blank1_q <= ctrl_q[0] ? 8'(SPLPP_OC_BLANK_CYC) : (blank1_q != 8'h00 ? blank1_q - 8'h01 : 8'h00);
      blank2_q <= ctrl_q[1] ? 8'(SPLPP_OC_BLANK_CYC) : (blank2_q != 8'h00 ? blank2_q - 8'h01 : 8'h00);
    end
  end

  // released pin high means the monitor reports overcurrent
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      oc_q <= 2'b00;
      oc_prev_q <= 2'b00;
    end else begin
      oc_q[0] <= !ctrl_q[0] && blank1_q == 8'h00 && p1_s;
      oc_q[1] <= !ctrl_q[1] && blank2_q == 8'h00 && p2_s;
      oc_prev_q <= oc_q;
    end
  end
  assign overcurrent_out = oc_q;

  // ***************************************
  // upstream power and link renegotiation
  // ***************************************
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      vbus_q <= 1'b0;
    end else begin
      vbus_q <= vbus_s;
    end
  end
  assign upstream_power_out = vbus_q;

  // a drop of upstream power detaches and reattaches only the link; straps
  // and port power stay untouched
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      link_q <= SPLPP_LINK_IDLE;
    end else begin
      case (link_q)
        SPLPP_LINK_IDLE: if (vbus_q && !ctrl_q[2]) link_q <= SPLPP_LINK_UP;
        SPLPP_LINK_UP: if (!vbus_q || ctrl_q[2]) link_q <= SPLPP_LINK_DROP;
        SPLPP_LINK_DROP: link_q <= SPLPP_LINK_IDLE;
        default: link_q <= SPLPP_LINK_IDLE;
      endcase
    end
  end
  assign link_attach_out = link_q == SPLPP_LINK_UP;

  // ***************************************
  // shared serial pins
  // ***************************************
  // rom_q: bit0 select, bit1 clock, bit2 data out
  assign rom_select_n_out = mgmt_mode_out ? 1'b1 : !rom_q[0];
  assign mgmt_bus_clock_out = mgmt_mode_out ? 1'b0 : rom_q[1];
  assign mgmt_bus_clock_oe_n_out = mgmt_mode_out ? 1'b1 : 1'b0;
  assign mgmt_bus_data_out = mgmt_mode_out ? 1'b0 : rom_q[2];
  assign mgmt_bus_data_oe_n_out = mgmt_mode_out ? 1'b1 : 1'b0;
  assign mgmt_scl_out = mgmt_mode_out && scl_s;
  assign mgmt_sda_out = mgmt_mode_out && sda_s;
  assign rom_miso_out = !mgmt_mode_out && miso_s;

  // ***************************************
  // interrupts
  // ***************************************
  assign ev = {vbus_q != vbus_s, oc_q & ~oc_prev_q};

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq_q <= 3'h0;
    end else begin
      irq_q <= (irq_q & ~((wr_in && addr_in == SPLPP_REG_IRQ) ? wdata_in[2:0] : 3'h0)) | ev;
    end
  end
  assign irq_out = |(irq_q & mask_q);

  // ***************************************
  // checks
  // ***************************************
  property p_strap_hold;
    @(posedge clk_in) disable iff (reset_in)
    !capture |=> $stable(strap_q);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap moved");

  property p_strap_cap;
    @(posedge clk_in) disable iff (reset_in)
    capture |=> strap_q[SPLPP_ST_CHARGE] == $past(charge_enable_strap_in);
  endproperty
  a_strap_cap: assert property (p_strap_cap) else $error("strap not captured");

  property p_drive;
    @(posedge clk_in) disable iff (reset_in)
    ctrl_q[0] |-> !port_one_power_ctl_oe_n_out && port_one_power_ctl_out;
  endproperty
  a_drive: assert property (p_drive) else $error("port 1 not powered");

  property p_oc;
    @(posedge clk_in) disable iff (reset_in)
    ctrl_q[1] |=> !overcurrent_out[1];
  endproperty
  a_oc: assert property (p_oc) else $error("overcurrent while driving");

  property p_vbus;
    @(posedge clk_in) disable iff (reset_in)
    !vbus_q [*2] |-> link_q != SPLPP_LINK_UP;
  endproperty
  a_vbus: assert property (p_vbus) else $error("link up without power");

  property p_reneg;
    @(posedge clk_in) disable iff (reset_in)
    (link_q == SPLPP_LINK_UP && !vbus_q) |=> link_q == SPLPP_LINK_DROP ##1 $stable(strap_q);
  endproperty
  a_reneg: assert property (p_reneg) else $error("no renegotiation");

  property p_rom;
    @(posedge clk_in) disable iff (reset_in)
    !mgmt_mode_out |-> rom_select_n_out == !rom_q[0] && !mgmt_bus_clock_oe_n_out;
  endproperty
  a_rom: assert property (p_rom) else $error("rom pins wrong");

  property p_mgmt;
    @(posedge clk_in) disable iff (reset_in)
    mgmt_mode_out |-> rom_select_n_out && mgmt_bus_data_oe_n_out && !mgmt_bus_clock_out;
  endproperty
  a_mgmt: assert property (p_mgmt) else $error("management pins wrong");

  property p_fixed;
    @(posedge clk_in) disable iff (reset_in)
    capture |=> fixed_port_count_out == $past(fixed_port_count_strap_in);
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed count wrong");
endmodule // splpp_top

// file: tb/splpp_partner.sv
// far side model: port power switches with monitors, and host bus power
`timescale 1ns/1ns
module splpp_partner (
  input wire logic clk_in, // bench clock
  input wire logic [1:0] drv_in, // device pin values
  input wire logic [1:0] oe_n_in, // device enables, low drives
  input wire logic [1:0] fault_in, // overcurrent at the switches
  input wire logic slow_in, // monitors flag late
  input wire logic host_pwr_in, // host supplies bus power
  output logic [1:0] pin_out, // port pin levels
  output logic up_pin_out // upstream sense level
);
  // ****
  // monitor flags
  // ****
  logic [7:0] lag_q;
  logic [1:0] flag;
  // a filtered monitor flags four cycles late
  always_ff @(posedge clk_in) begin
    lag_q <= {lag_q[5:0], fault_in};
  end
  assign flag = slow_in ? lag_q[7:6] : fault_in;
  // a driving device wins; a released pin carries the monitor flag
  assign pin_out[0] = oe_n_in[0] ? flag[0] : drv_in[0];
  assign pin_out[1] = oe_n_in[1] ? flag[1] : drv_in[1];
  // host may toggle bus power to renegotiate
  assign up_pin_out = host_pwr_in;
endmodule // splpp_partner

// file: tb/splpp_top_tb.sv
// self-checking bench for the strap latch and port power pin block
`timescale 1ns/1ns
module splpp_top_tb
  import splpp_pkg::*;
;
  logic clk_in, reset_in, ext_n, charge_s, mgmt_s, host_pwr, rom_si, scl_h, sda_h;
  logic wr_in, rd_in, p1_oe_n, p2_oe_n, p1_drv, p2_drv, sel_n, scl_o, scl_oe_n, sda_o;
  logic sda_oe_n, charge_o, mgmt_o, upwr_o, link_o, scl_s, sda_s, miso_s, irq, slow;
  logic up_pin, scl_w, sda_w;
  logic rd_seen = 1'b0;
  logic [1:0] fixed_s, fixed_o, oc_o, fault, pins;
  logic [3:0] addr_in, st, v;
  logic [7:0] wdata_in, rdata;
  logic [7:0] exp_q[$];
  int seed, mismatches = 0, n_compared = 0;
  // open-drain wires: released pins follow the bus master
  assign scl_w = scl_oe_n ? scl_h : scl_o;
  assign sda_w = sda_oe_n ? sda_h : sda_o;
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  splpp_top dut (
    .clk_in(clk_in), .reset_in(reset_in), .ext_reset_n_in(ext_n),
    .fixed_port_count_strap_in(fixed_s), .charge_enable_strap_in(charge_s),
    .mgmt_mode_strap_in(mgmt_s), .upstream_power_sense_in(up_pin),
    .port_one_power_ctl_in(pins[0]), .port_one_power_ctl_out(p1_drv),
    .port_one_power_ctl_oe_n_out(p1_oe_n), .port_two_power_ctl_in(pins[1]),
    .port_two_power_ctl_out(p2_drv), .port_two_power_ctl_oe_n_out(p2_oe_n),
    .rom_select_n_out(sel_n), .mgmt_bus_clock_in(scl_w), .mgmt_bus_clock_out(scl_o),
    .mgmt_bus_clock_oe_n_out(scl_oe_n), .mgmt_bus_data_in(sda_w),
    .mgmt_bus_data_out(sda_o), .mgmt_bus_data_oe_n_out(sda_oe_n), .rom_serial_in(rom_si),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
    .fixed_port_count_out(fixed_o), .charge_enable_out(charge_o), .mgmt_mode_out(mgmt_o),
    .upstream_power_out(upwr_o), .link_attach_out(link_o), .overcurrent_out(oc_o),
    .mgmt_scl_out(scl_s), .mgmt_sda_out(sda_s), .rom_miso_out(miso_s), .irq_out(irq)
  );
  splpp_partner far (
    .clk_in(clk_in), .drv_in({p2_drv, p1_drv}), .oe_n_in({p2_oe_n, p1_oe_n}),
    .fault_in(fault), .slow_in(slow), .host_pwr_in(host_pwr), .pin_out(pins),
    .up_pin_out(up_pin)
  );
  // ****
  // shared tasks
  // ****
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // the expected read value is queued as the strobe goes out
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_in);
    rd_in <= 1'b0;
  endtask
  task automatic done(input string name);
    $display("test %s done", name);
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge clk_in) begin
    if (rd_seen) chk(rdata, exp_q.pop_front());
    rd_seen <= rd_in;
  end
  // cut a hang short
  initial begin
    tick(5000);
    mismatches++;
    close_out();
  end
  // ****
  // scenarios
  // ****
  initial begin
    seed = 32'h088e;
    st = 4'($random(seed)) & 4'h7;
    reset_in = 1'b1;
    ext_n = 1'b1;
    host_pwr = 1'b1;
    slow = 1'b0;
    fault = 2'b00;
    rom_si = 1'b0;
    scl_h = 1'b1;
    sda_h = 1'b1;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 4'h0;
    wdata_in = 8'h00;
    {mgmt_s, charge_s, fixed_s} = st;
    tick(8);
    reset_in <= 1'b0;
    tick(3);
    // power-on capture, then the pins move but the latch holds
    rd_reg(SPLPP_REG_STRAP, {4'h0, st});
    {mgmt_s, charge_s, fixed_s} <= ~st & 4'h7;
    tick(6);
    rd_reg(SPLPP_REG_STRAP, {4'h0, st});
    chk({mgmt_o, charge_o, fixed_o}, st);
    done("straps");
    // power both ports, then release port one into a live, late fault
    wr_reg(SPLPP_REG_MASK, 8'h00);
    wr_reg(SPLPP_REG_CTRL, 8'h03);
    fault <= 2'b01;
    slow <= 1'b1;
    tick(2);
    chk({p2_oe_n, p1_oe_n, p2_drv, p1_drv}, 8'h03);
    chk(oc_o, 8'h00);
    wr_reg(SPLPP_REG_CTRL, 8'h02);
    tick(8);
    chk(oc_o, 8'h00);
    for (int i = 0; i < 40 && oc_o !== 2'b01; i++) @(posedge clk_in);
    chk(oc_o, 8'h01);
    chk(irq, 8'h00);
    wr_reg(SPLPP_REG_MASK, 8'h07);
    tick(2);
    chk(irq, 8'h01);
    // bus power seen after reset already counts as an upstream change
    rd_reg(SPLPP_REG_IRQ, 8'h05);
    wr_reg(SPLPP_REG_IRQ, 8'h05);
    tick(2);
    chk(irq, 8'h00);
    rd_reg(SPLPP_REG_IRQ, 8'h00);
    done("ports");
    // host drops bus power and restores it; nothing else is reset
    host_pwr <= 1'b0;
    for (int i = 0; i < 20 && link_o !== 1'b0; i++) @(posedge clk_in);
    tick(2);
    chk({link_o, upwr_o}, 8'h00);
    rd_reg(SPLPP_REG_STAT, 8'h01);
    host_pwr <= 1'b1;
    for (int i = 0; i < 20 && link_o !== 1'b1; i++) @(posedge clk_in);
    chk({link_o, upwr_o}, 8'h03);
    // soft detach drops the link with power still present, then reattaches
    wr_reg(SPLPP_REG_CTRL, 8'h06);
    tick(3);
    chk(link_o, 8'h00);
    wr_reg(SPLPP_REG_CTRL, 8'h02);
    tick(3);
    chk(link_o, 8'h01);
    rd_reg(SPLPP_REG_CTRL, 8'h02);
    rd_reg(SPLPP_REG_IRQ, 8'h04);
    rd_reg(SPLPP_REG_STRAP, {4'h0, st});
    done("upstream");
    // rom mode: select, clock and data follow the rom register
    for (int k = 0; k < 6; k++) begin
      v = 4'($random(seed));
      wr_reg(SPLPP_REG_ROM, {5'h00, v[2:0]});
      rom_si <= v[3];
      tick(6);
      chk({sel_n, scl_oe_n, scl_o, sda_oe_n, sda_o}, {~v[0], 1'b0, v[1], 1'b0, v[2]});
      chk(miso_s, v[3]);
    end
    done("rom");
    // external reset release recaptures the straps in management mode
    st = 4'($random(seed)) | 4'h8;
    ext_n <= 1'b0;
    {mgmt_s, charge_s, fixed_s} <= st;
    tick(4);
    ext_n <= 1'b1;
    for (int i = 0; i < 20 && mgmt_o !== 1'b1; i++) @(posedge clk_in);
    tick(2);
    {mgmt_s, charge_s, fixed_s} <= 4'h0;
    rd_reg(SPLPP_REG_STRAP, {4'h0, st});
    chk({mgmt_o, charge_o, fixed_o}, st);
    chk({sel_n, scl_oe_n, sda_oe_n}, 8'h07);
    for (int k = 0; k < 4; k++) begin
      v = 4'($random(seed));
      scl_h <= v[0];
      sda_h <= v[1];
      tick(6);
      chk({scl_s, sda_s}, {v[0], v[1]});
    end
    // unmapped place reads zero, the strap word refuses writes
    rd_reg(4'hf, 8'h00);
    wr_reg(SPLPP_REG_STRAP, 8'h00);
    rd_reg(SPLPP_REG_STRAP, {4'h0, st});
    rd_reg(SPLPP_REG_CTRL, 8'h02);
    done("mgmt");
    tick(4);
    close_out();
  end
endmodule // splpp_top_tb
